/* hw/tws_pkg.sv */
/*
 * constants, state codes and reset values of the two-wire register slave.
 * assumes a single system clock well above the serial clock rate.
 */
package tws_pkg;
	localparam int REG_ADDR_W = 8;
	localparam int REG_DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int PIN_COUNT = 4;
	// upper five bits of the 7-bit slave address, low two come from pins
	localparam logic [4:0] DEV_ADDR_HI = 5'h17;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic DIR_READ = 1'h1;
	localparam logic [REG_ADDR_W-1:0] PTR_RST = 8'h00;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	localparam logic [REG_DATA_W-1:0] WORD_RST = 16'h0000;
	localparam logic [PIN_COUNT-1:0] PIN_RST = 4'hF;

	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_ADDR = 10'h002,
		ST_ADDR_ACK = 10'h004,
		ST_REG = 10'h008,
		ST_REG_ACK = 10'h010,
		ST_WDATA = 10'h020,
		ST_WDATA_ACK = 10'h040,
		ST_RDATA = 10'h080,
		ST_RDATA_ACK = 10'h100,
		ST_IGNORE = 10'h200
	} tws_state_e;
endpackage : tws_pkg

/* hw/tws_mem_if.sv */
/*
 * link between the serial engine and its register memory.
 * assumes both ends share one clock.
 */
`timescale 1ns/100ps
interface tws_mem_if #(
	parameter int AW = tws_pkg::REG_ADDR_W,
	parameter int DW = tws_pkg::REG_DATA_W
) ();
	logic wr_en;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport ctrl (output wr_en, output waddr, output wdata, output raddr,
		input rdata);
	modport mem (input wr_en, input waddr, input wdata, input raddr,
		output rdata);
endinterface : tws_mem_if

/* hw/tws_reg_mem.sv */
/*
 * 16-bit register file with one write port and two registered read ports.
 * assumes writes and reads come from the same clock domain.
 */
`timescale 1ns/100ps
module tws_reg_mem #(
	parameter int AW = tws_pkg::REG_ADDR_W,
	parameter int DW = tws_pkg::REG_DATA_W
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	tws_mem_if.mem bus,
	input wire logic [AW-1:0] core_raddr_i,
	output logic [DW-1:0] core_rdata_o
);
	import tws_pkg::*;

	logic [DW-1:0] mem_q [2**AW];

	// -------------------------------------------------------------
	// storage
	// -------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (bus.wr_en) begin
			mem_q[bus.waddr] <= bus.wdata;
		end
	end

	// -------------------------------------------------------------
	// registered reads
	// -------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus.rdata <= WORD_RST;
			core_rdata_o <= WORD_RST;
		end else begin
			bus.rdata <= mem_q[bus.raddr];
			core_rdata_o <= mem_q[core_raddr_i];
		end
	end
endmodule : tws_reg_mem

/* hw/tws_slave.sv */
/*
 * two-wire serial slave giving a bus master access to 16-bit registers.
 * assumes an external pull-up on the data line and a system clock at
 * least eight times faster than the serial clock.
 */
// Notes on behaviour
// - address byte bit 0 picks direction: 0 write, 1 read.
// - low two slave address bits come from the two select pins.
// - with both select pins low, master uses B8 write, B9 read.
// - matching address byte after start is acknowledged.
// - write: register address byte follows slave address, acknowledged.
// - registers are 16 bits, two bytes each, every written byte acked.
// - register changes only after both bytes of a word arrive.
// - write pointer advances after each full word.
// - read: device sends bytes, master acks, pointer advances per word.
// - master nack ends a read; device then releases data line.
// - bus idle when both lines high; device never makes start or stop.
// - start is data falling while clock high; begins new transaction.
// - stop is data rising while clock high; returns to idle.
// - one bit per clock pulse; data changes only while clock low.
// - every unit is eight data bits plus one acknowledge slot.
// - transmitter releases line in ack slot; receiver pulls it low.
// - line left high in the ack slot means no-acknowledge.
// - line is only pulled low or released, never driven high.
`timescale 1ns/100ps
module tws_slave (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic serial_clk_i,
	input wire logic serial_data_in_i,
	input wire logic addr_select_bit0_i,
	input wire logic addr_select_bit1_i,
	input wire logic [tws_pkg::REG_ADDR_W-1:0] core_raddr_i,
	output logic serial_data_out_o,
	output logic serial_data_oe_o,
	output logic reg_wr_o,
	output logic [tws_pkg::REG_ADDR_W-1:0] reg_waddr_o,
	output logic [tws_pkg::REG_DATA_W-1:0] reg_wdata_o,
	output logic [tws_pkg::REG_DATA_W-1:0] core_rdata_o
);
	import tws_pkg::*;

	tws_mem_if #(.AW(REG_ADDR_W), .DW(REG_DATA_W)) mem_bus ();

	logic [PIN_COUNT-1:0] pin_meta_q;
	logic [PIN_COUNT-1:0] pin_sync_q;
	logic scl_prev_q;
	logic sda_prev_q;
	tws_state_e state_q, state_d;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	logic [BYTE_W-1:0] shift_q, shift_d;
	logic [BYTE_W-1:0] tx_q, tx_d;
	logic [BYTE_W-1:0] hold_q, hold_d;
	logic [REG_ADDR_W-1:0] ptr_q, ptr_d;
	logic hi_q, hi_d;
	logic dir_q, dir_d;
	logic nack_q, nack_d;
	logic oe_q, oe_d;
	logic wr_q, wr_d;
	logic [REG_ADDR_W-1:0] waddr_q, waddr_d;
	logic [REG_DATA_W-1:0] wdata_q, wdata_d;
	logic out_q;

	// -------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------
	wire [PIN_COUNT-1:0] pins_w = {addr_select_bit1_i, addr_select_bit0_i,
		serial_data_in_i, serial_clk_i};

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_meta_q <= PIN_RST;
			pin_sync_q <= PIN_RST;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			pin_meta_q <= pins_w;
			pin_sync_q <= pin_meta_q;
			scl_prev_q <= pin_sync_q[0];
			sda_prev_q <= pin_sync_q[1];
		end
	end

	// -------------------------------------------------------------
	// line decoding
	// -------------------------------------------------------------
	wire scl_w = pin_sync_q[0];
	wire sda_w = pin_sync_q[1];
	wire scl_rise_w = scl_w & ~scl_prev_q;
	wire scl_fall_w = ~scl_w & scl_prev_q;
	wire scl_hold_w = scl_w & scl_prev_q;
	wire start_w = scl_hold_w & sda_prev_q & ~sda_w;
	wire stop_w = scl_hold_w & ~sda_prev_q & sda_w;
	wire [6:0] own_addr_w = {DEV_ADDR_HI, pin_sync_q[3:2]};
	wire addr_hit_w = (shift_q[7:1] == own_addr_w);
	wire byte_done_w = (bit_cnt_q == BITS_PER_BYTE);
	wire [BYTE_W-1:0] rd_byte_w = hi_q ? mem_bus.rdata[15:8]
		: mem_bus.rdata[7:0];
	wire [REG_ADDR_W-1:0] ptr_inc_w = REG_ADDR_W'(ptr_q + 8'h01);
	wire [BYTE_W-1:0] shift_in_w = {shift_q[6:0], sda_w};
	wire [3:0] cnt_inc_w = 4'(bit_cnt_q + 4'h1);

	assign mem_bus.wr_en = wr_q;
	assign mem_bus.waddr = waddr_q;
	assign mem_bus.wdata = wdata_q;
	assign mem_bus.raddr = ptr_q;

	// -------------------------------------------------------------
	// protocol engine
	// -------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		bit_cnt_d = bit_cnt_q;
		shift_d = shift_q;
		tx_d = tx_q;
		hold_d = hold_q;
		ptr_d = ptr_q;
		hi_d = hi_q;
		dir_d = dir_q;
		nack_d = nack_q;
		oe_d = oe_q;
		wr_d = 1'b0;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		if (start_w) begin
			state_d = ST_ADDR;
			bit_cnt_d = 4'h0;
			oe_d = 1'b0;
		end else if (stop_w) begin
			state_d = ST_IDLE;
			oe_d = 1'b0;
		end else begin
			unique case (state_q)
			ST_IDLE, ST_IGNORE: begin
				oe_d = 1'b0;
			end
			ST_ADDR, ST_REG, ST_WDATA: begin
				if (scl_rise_w && !byte_done_w) begin
					shift_d = shift_in_w;
					bit_cnt_d = cnt_inc_w;
				end
				if (scl_fall_w && byte_done_w) begin
					oe_d = 1'b1;
					if (state_q == ST_ADDR) begin
						dir_d = shift_q[0];
						hi_d = 1'b1;
						state_d = addr_hit_w ? ST_ADDR_ACK : ST_IGNORE;
						oe_d = addr_hit_w;
					end else if (state_q == ST_REG) begin
						ptr_d = shift_q;
						hi_d = 1'b1;
						state_d = ST_REG_ACK;
					end else begin
						state_d = ST_WDATA_ACK;
						hi_d = ~hi_q;
						if (hi_q) begin
							hold_d = shift_q;
						end else begin
							wr_d = 1'b1;
							waddr_d = ptr_q;
							wdata_d = {hold_q, shift_q};
							ptr_d = ptr_inc_w;
						end
					end
				end
			end
			ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
				if (scl_fall_w) begin
					oe_d = 1'b0;
					bit_cnt_d = 4'h0;
					if (state_q == ST_ADDR_ACK && dir_q == DIR_READ) begin
						tx_d = rd_byte_w;
						oe_d = ~rd_byte_w[7];
						state_d = ST_RDATA;
					end else if (state_q == ST_ADDR_ACK) begin
						state_d = ST_REG;
					end else begin
						state_d = ST_WDATA;
					end
				end
			end
			ST_RDATA: begin
				if (scl_rise_w && !byte_done_w) begin
					bit_cnt_d = cnt_inc_w;
				end
				if (scl_fall_w) begin
					if (byte_done_w) begin
						oe_d = 1'b0;
						state_d = ST_RDATA_ACK;
						hi_d = ~hi_q;
						if (!hi_q) begin
							ptr_d = ptr_inc_w;
						end
					end else begin
						tx_d = {tx_q[6:0], 1'b0};
						oe_d = ~tx_q[6];
					end
				end
			end
			ST_RDATA_ACK: begin
				if (scl_rise_w) begin
					nack_d = sda_w;
				end
				if (scl_fall_w) begin
					bit_cnt_d = 4'h0;
					if (nack_q) begin
						state_d = ST_IGNORE;
					end else begin
						tx_d = rd_byte_w;
						oe_d = ~rd_byte_w[7];
						state_d = ST_RDATA;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
				oe_d = 1'b0;
			end
			endcase
		end
	end

	// -------------------------------------------------------------
	// state registers
	// -------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= BYTE_RST;
			tx_q <= BYTE_RST;
			hold_q <= BYTE_RST;
			ptr_q <= PTR_RST;
			hi_q <= 1'b1;
			dir_q <= 1'b0;
			nack_q <= 1'b0;
			oe_q <= 1'b0;
			wr_q <= 1'b0;
			waddr_q <= PTR_RST;
			wdata_q <= WORD_RST;
			out_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			tx_q <= tx_d;
			hold_q <= hold_d;
			ptr_q <= ptr_d;
			hi_q <= hi_d;
			dir_q <= dir_d;
			nack_q <= nack_d;
			oe_q <= oe_d;
			wr_q <= wr_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			out_q <= 1'b0;
		end
	end

	assign serial_data_out_o = out_q;
	assign serial_data_oe_o = oe_q;
	assign reg_wr_o = wr_q;
	assign reg_waddr_o = waddr_q;
	assign reg_wdata_o = wdata_q;

	// -------------------------------------------------------------
	// register memory
	// -------------------------------------------------------------
	tws_reg_mem #(.AW(REG_ADDR_W), .DW(REG_DATA_W)) tws_reg_mem_inst (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.bus(mem_bus.mem),
		.core_raddr_i(core_raddr_i),
		.core_rdata_o(core_rdata_o)
	);

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	chk_never_drive_high: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) serial_data_oe_o |-> !serial_data_out_o
		&& state_q inside {ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK,
		ST_RDATA})
		else $error("data line driven high or out of turn");

	chk_start_begins: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) start_w |=> state_q == ST_ADDR && !oe_q
		&& bit_cnt_q == 4'h0)
		else $error("start did not open a transaction");

	chk_stop_releases: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) stop_w && !start_w
		|=> state_q == ST_IDLE && !oe_q)
		else $error("stop did not release the bus");

	chk_quiet_states: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		(state_q == ST_IDLE || state_q == ST_IGNORE) |-> !oe_q)
		else $error("data line pulled while not addressed");

	chk_steady_high: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) scl_w && !start_w && !stop_w
		|=> oe_q == $past(oe_q))
		else $error("data changed while clock high");

	chk_addr_ack: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) state_q == ST_ADDR && scl_fall_w
		&& byte_done_w && addr_hit_w && !start_w && !stop_w
		|=> state_q == ST_ADDR_ACK && oe_q)
		else $error("own address not acknowledged");

	chk_full_word: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) wr_q |-> $past(state_q) == ST_WDATA
		&& !$past(hi_q) && wdata_q[7:0] == $past(shift_q))
		else $error("register written before a full word");

	chk_write_incr: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		wr_q |-> ptr_q == REG_ADDR_W'(waddr_q + 8'h01))
		else $error("pointer did not advance after a word");

	chk_read_incr: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) state_q == ST_RDATA && scl_fall_w
		&& byte_done_w && !hi_q
		|=> ptr_q == REG_ADDR_W'($past(ptr_q) + 8'h01))
		else $error("read pointer did not advance");

	chk_nack_release: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) state_q == ST_RDATA_ACK && scl_fall_w
		&& nack_q && !start_w && !stop_w
		|=> state_q == ST_IGNORE ##1 !oe_q)
		else $error("nack did not end the read");
endmodule : tws_slave

/* verification/tws_bus_master.sv */
/*
 * two-wire bus master model: drives the serial clock and pulls data low.
 * assumes an external pull-up on data and the bench reference clock.
 */
`timescale 1ns/100ps
module tws_bus_master (
	input wire logic ref_clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_pull_o
);
	// ----------------------------------------
	// bus timing
	// ----------------------------------------
	// high phase length, raised to slow the bus
	int hi_cycles = 10;

	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : wait_clk

	// start or repeated start: data falls while clock high
	task automatic start_cond();
		sda_pull_o = 1'b0;
		wait_clk(5);
		scl_o = 1'b1;
		wait_clk(5);
		sda_pull_o = 1'b1;
		wait_clk(5);
		scl_o = 1'b0;
		wait_clk(5);
	endtask : start_cond

	// stop: data rises while clock high
	task automatic stop_cond();
		sda_pull_o = 1'b1;
		wait_clk(5);
		scl_o = 1'b1;
		wait_clk(5);
		sda_pull_o = 1'b0;
		wait_clk(5);
	endtask : stop_cond

	// data set in low phase, sampled at end of high phase
	task automatic bit_xfer(input logic b, output logic r);
		sda_pull_o = ~b;
		wait_clk(5);
		scl_o = 1'b1;
		wait_clk(hi_cycles);
		r = sda_i;
		scl_o = 1'b0;
		wait_clk(5);
	endtask : bit_xfer

	// msb first, then ack slot with data released
	task automatic write_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
		bit_xfer(1'b1, r);
		ack = ~r;
	endtask : write_byte

	// receive a byte, then ack or nack it
	task automatic read_byte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_xfer(1'b1, b[i]);
		bit_xfer(last, r);
	endtask : read_byte
endmodule : tws_bus_master

/* verification/two_wire_register_slave_tb.sv */
/*
 * self-checking bench for the two-wire register slave.
 * assumes the bus master model and a pull-up resolved here.
 */
`timescale 1ns/100ps
module two_wire_register_slave_tb;
	import tws_pkg::*;
	logic ref_clk, rst_n, scl, sda_pull, sda_line, sel0, sel1;
	logic oe, dout, wr;
	logic [7:0] craddr, waddr;
	logic [15:0] wdata, crdata;
	logic [23:0] exp_q [$];
	logic [15:0] shadow [256];
	int err_total = 0;
	int samples_checked = 0;

	// open-drain line with pull-up
	assign sda_line = (oe === 1'b1 || sda_pull === 1'b1) ? 1'b0 : 1'b1;

	tws_slave tws_slave_inst (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
		.serial_clk_i(scl), .serial_data_in_i(sda_line),
		.addr_select_bit0_i(sel0), .addr_select_bit1_i(sel1),
		.core_raddr_i(craddr), .serial_data_out_o(dout),
		.serial_data_oe_o(oe), .reg_wr_o(wr), .reg_waddr_o(waddr),
		.reg_wdata_o(wdata), .core_rdata_o(crdata));
	tws_bus_master tws_bus_master_inst (.ref_clk_i(ref_clk),
		.sda_i(sda_line), .scl_o(scl), .sda_pull_o(sda_pull));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// checking
	// ----------------------------------------
	function automatic logic [23:0] b1(input logic x);
		return {23'h0, x};
	endfunction : b1

	task automatic check(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	// commits taken off the queue, sampled mid-cycle where settled
	always @(negedge ref_clk) begin
		if (rst_n === 1'b1 && wr === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("commit count", 24'h0, 24'h1);
			end else begin
				check("commit", exp_q.pop_front(), {waddr, wdata});
			end
		end
		if (oe === 1'b1 && dout !== 1'b0) begin
			check("drive", 24'h0, b1(dout));
		end
	end

	initial begin
		repeat (100000) @(posedge ref_clk);
		err_total++;
		$display("unexpected cycles: expected under 100000 seen 100000");
		print_verdict();
	end

	// ----------------------------------------
	// transfers
	// ----------------------------------------
	task automatic wr_burst(input logic [7:0] dev, input logic [7:0] r,
		input int n, input logic hit);
		logic a;
		logic [15:0] w;
		tws_bus_master_inst.start_cond();
		tws_bus_master_inst.write_byte(dev, a);
		check("addr ack", b1(hit), b1(a));
		tws_bus_master_inst.write_byte(r, a);
		check("reg ack", b1(hit), b1(a));
		for (int i = 0; i < n; i++) begin
			w = 16'($urandom);
			if (hit) begin
				exp_q.push_back({8'(r + i), w});
				shadow[8'(r + i)] = w;
			end
			tws_bus_master_inst.write_byte(w[15:8], a);
			check("upper ack", b1(hit), b1(a));
			tws_bus_master_inst.write_byte(w[7:0], a);
			check("lower ack", b1(hit), b1(a));
		end
	endtask : wr_burst

	task automatic rd_burst(input logic [7:0] dev, input logic [7:0] r,
		input int n);
		logic a;
		logic [7:0] hi, lo;
		wr_burst(dev, r, 0, 1'b1);
		tws_bus_master_inst.start_cond();
		tws_bus_master_inst.write_byte(dev | 8'h01, a);
		check("read addr ack", b1(1'b1), b1(a));
		for (int i = 0; i < n; i++) begin
			tws_bus_master_inst.read_byte(1'b0, hi);
			tws_bus_master_inst.read_byte(i == n - 1, lo);
			check("read word", {8'(r + i), shadow[8'(r + i)]},
				{8'(r + i), hi, lo});
		end
		check("released", b1(1'b0), b1(oe));
		tws_bus_master_inst.stop_cond();
	endtask : rd_burst

	task automatic end_test(input string name);
		for (int k = 0; k < 50 && exp_q.size() > 0; k++) @(negedge ref_clk);
		if (exp_q.size() != 0) begin
			err_total++;
			$display("unexpected pending commits: expected 0 seen %0d",
				exp_q.size());
		end
		$display("test %s done", name);
	endtask : end_test

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		logic a;
		logic [7:0] r;
		rst_n = 1'b0;
		sel0 = 1'b0;
		sel1 = 1'b0;
		craddr = 8'h00;
		void'($urandom(41183));
		repeat (12) @(negedge ref_clk);
		rst_n = 1'b1;
		@(negedge ref_clk);
		check("reset outputs", 24'h0, {21'h0, oe, dout, wr});
		repeat (7) @(negedge ref_clk);
		for (int p = 0; p < 4; p++) begin
			{sel1, sel0} = 2'(p);
			repeat (4) @(negedge ref_clk);
			wr_burst(8'hB8 + 8'(2 * ((p + 1) % 4)), 8'h10, 1, 1'b0);
			tws_bus_master_inst.stop_cond();
			wr_burst(8'hB8 + 8'(2 * p), 8'(8'h10 * p), 2, 1'b1);
			tws_bus_master_inst.stop_cond();
		end
		rd_burst(8'hBE, 8'h30, 2);
		craddr = 8'h31;
		repeat (3) @(negedge ref_clk);
		check("core port", {8'h31, shadow[8'h31]}, {craddr, crdata});
		{sel1, sel0} = 2'b00;
		repeat (4) @(negedge ref_clk);
		rd_burst(8'hB8, 8'h00, 2);
		end_test("addresses");
		wr_burst(8'hB8, 8'h40, 1, 1'b1);
		tws_bus_master_inst.stop_cond();
		wr_burst(8'hB8, 8'h40, 0, 1'b1);
		tws_bus_master_inst.write_byte(~shadow[8'h40][15:8], a);
		check("partial ack", b1(1'b1), b1(a));
		tws_bus_master_inst.stop_cond();
		rd_burst(8'hB8, 8'h40, 1);
		end_test("partial word");
		wr_burst(8'hB8, 8'hFF, 2, 1'b1);
		tws_bus_master_inst.stop_cond();
		rd_burst(8'hB8, 8'hFF, 2);
		end_test("pointer wrap");
		tws_bus_master_inst.hi_cycles = 30;
		wr_burst(8'hB8, 8'h50, 1, 1'b1);
		rd_burst(8'hB8, 8'h50, 1);
		tws_bus_master_inst.hi_cycles = 10;
		end_test("slow bus");
		for (int k = 0; k < 4; k++) begin
			r = 8'($urandom);
			wr_burst(8'hB8, r, 3, 1'b1);
			tws_bus_master_inst.stop_cond();
			rd_burst(8'hB8, r, 3);
		end
		end_test("random bursts");
		print_verdict();
	end
endmodule : two_wire_register_slave_tb
